// *** dv/dpsa_link_properties.sv ***
`timescale 1ns/1ps
module dpsa_link_properties (
	input wire logic hclk,       // clock
	input wire logic hresetn,    // async reset, active low
	input wire logic scl,        // resolved clock line
	input wire logic sda,        // resolved data line
	input wire logic m_scl_o,    // host clock drive
	input wire logic m_scl_oe_n, // host clock enable
	input wire logic m_sda_o,    // host data drive
	input wire logic m_sda_oe_n, // host data enable
	input wire logic s_sda_o,    // device data drive
	input wire logic s_sda_oe_n  // device data enable
);
	logic       scl_q;
	logic       sda_q;
	logic [3:0] bit_q;
	logic       first_q;
	logic       rd_q;
	logic       start_ev;
	logic       rise_ev;
	// ----------------------------------------
	// line tracking
	// ----------------------------------------
	assign start_ev = scl && scl_q && sda_q && !sda;
	assign rise_ev  = scl && !scl_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end
	// bit number within the byte, 1..9, and which byte we are in
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bit_q   <= 4'h0;
			first_q <= 1'b0;
			rd_q    <= 1'b0;
		end else if (start_ev) begin
			bit_q   <= 4'h0;
			first_q <= 1'b1;
			rd_q    <= 1'b0;
		end else if (rise_ev) begin
			bit_q <= (bit_q == 4'h9) ? 4'h1 : bit_q + 4'h1;
			if (bit_q == 4'h9)
				first_q <= 1'b0;
			if (first_q && bit_q == 4'h7)
				rd_q <= sda;
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence rise_seq;
		scl && !scl_q;
	endsequence
	sequence stop_seq;
		scl && scl_q && !sda_q && sda;
	endsequence
	a_dev_od_pair: assert property (s_sda_o == s_sda_oe_n)
		else $error("device data drive and enable differ");
	a_host_scl_pair: assert property (m_scl_o == m_scl_oe_n)
		else $error("host clock drive and enable differ");
	a_host_sda_pair: assert property (m_sda_o == m_sda_oe_n)
		else $error("host data drive and enable differ");
	a_dev_pull_low: assert property ($fell(s_sda_oe_n) |-> !scl)
		else $error("device pulled data while clock high");
	a_dev_hold_high: assert property (
		rise_seq |-> $stable(s_sda_oe_n)[*3])
		else $error("device data moved at clock rise");
	a_stop_release: assert property (stop_seq |-> s_sda_oe_n[*8])
		else $error("device drives data after stop");
	a_addr_no_drive: assert property (
		rise_seq ##0 (first_q && bit_q < 4'h8) |-> s_sda_oe_n)
		else $error("device drives during address bits");
	a_wr_ack_only: assert property (
		rise_seq ##0 (!rd_q && bit_q != 4'h8) |-> s_sda_oe_n)
		else $error("device drives outside ack slot in write");
	a_rd_no_ack: assert property (
		rise_seq ##0 (rd_q && !first_q && bit_q == 4'h8) |-> s_sda_oe_n)
		else $error("device drives master ack slot");
endmodule

// *** dv/dpsa_tb_top.sv ***
`timescale 1ns/1ps
`include "dpsa_regs.svh"
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
	err_count++; $display("unexpected %s: expected %0h, seen %0h", \
	nm, ex, got); end end
module dpsa_tb_top;
	import dpsa_pkg::*;
	localparam int         LIMIT = 90000;
	localparam logic [7:0] TOL_I = 8'h9C;
	localparam logic [7:0] TOL_F = 8'h0F;
	logic        hclk;
	logic        hresetn;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic [31:0] hrdata;
	logic        hresp;
	dpsa_pin_t   pin_lo;
	dpsa_pin_t   pin_hi;
	logic [7:0]  wiper;
	logic        wp_active;
	logic        nv_busy;
	logic [31:0] st;
	logic [6:0]  dev_a;
	int          err_count;
	int          check_count;
	int          cyc;
	dpsa_if i_dpsa_if ();
	dpsa_dev #(.NV_WRITE_US(3), .TOL_SIGN_INT(TOL_I),
		.TOL_FRAC(TOL_F)) i_dpsa_dev (
		.hclk(hclk), .hresetn(hresetn), .bus(i_dpsa_if),
		.addr_sel_pin_low(pin_lo), .addr_sel_pin_high(pin_hi),
		.wiper(wiper), .wp_active(wp_active), .nv_busy(nv_busy));
	dpsa_host i_dpsa_host (
		.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .bus(i_dpsa_if));
	dpsa_link_properties i_dpsa_link_properties (
		.hclk(hclk), .hresetn(hresetn), .scl(i_dpsa_if.scl),
		.sda(i_dpsa_if.sda), .m_scl_o(i_dpsa_if.m_scl_o),
		.m_scl_oe_n(i_dpsa_if.m_scl_oe_n), .m_sda_o(i_dpsa_if.m_sda_o),
		.m_sda_oe_n(i_dpsa_if.m_sda_oe_n), .s_sda_o(i_dpsa_if.s_sda_o),
		.s_sda_oe_n(i_dpsa_if.s_sda_oe_n));
	// ----------------------------------------
	// bus and link helpers
	// ----------------------------------------
	task automatic ahb(input logic wr, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] q);
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	// one host step; busy is polled since byte steps take many ticks
	task automatic step(input dpsa_op_t op, input logic [7:0] b);
		int n;
		n = 0;
		ahb(1'b1, 32'(`DPSA_REG_CMD), {16'h0000, b, 5'h00, op}, st);
		do begin
			ahb(1'b0, 32'(`DPSA_REG_STATUS), 32'h0, st);
			n++;
		end while (st[`DPSA_ST_BUSY] !== 1'b0 && n < 500);
		`CHK("busy", 1'b0, st[`DPSA_ST_BUSY])
	endtask
	task automatic put(input logic [7:0] b, input logic ack);
		step(OP_WRITE, b);
		`CHK("ack", ack, st[`DPSA_ST_ACK])
	endtask
	task automatic get(input dpsa_op_t op, input logic [7:0] ex);
		step(op, 8'h00);
		`CHK("read byte", ex, st[`DPSA_DAT_MSB:`DPSA_DAT_LSB])
	endtask
	task automatic wr_xfer(input logic [7:0] ins, input logic [7:0] dat,
		input logic nd);
		step(OP_START, 8'h00);
		put({dev_a, 1'b0}, 1'b1);
		put(ins, 1'b1);
		if (nd)
			put(dat, 1'b1);
		step(OP_STOP, 8'h00);
	endtask
	// pointing bytes, repeated start, read address
	task automatic rd_ptr(input logic [7:0] ins);
		step(OP_START, 8'h00);
		put({dev_a, 1'b0}, 1'b1);
		put(ins, 1'b1);
		step(OP_START, 8'h00);
		put({dev_a, 1'b1}, 1'b1);
	endtask
	task automatic wait_nv();
		int n;
		n = 0;
		while (nv_busy !== 1'b0 && n < 5000) begin
			@(posedge hclk);
			n++;
		end
		`CHK("nv busy", 1'b0, nv_busy)
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		logic [31:0] q;
		`CHK("wiper", 8'h80, wiper)
		`CHK("protect", 1'b0, wp_active)
		`CHK("hresp", 1'b0, hresp)
		ahb(1'b0, 32'(`DPSA_REG_DIV), 32'h0, q);
		`CHK("div", 32'(`DPSA_DIV_RST), q)
		ahb(1'b1, 32'(`DPSA_REG_DIV), 32'h4, q);
		ahb(1'b0, 32'(`DPSA_REG_DIV), 32'h0, q);
		`CHK("div", 32'h4, q)
		ahb(1'b0, 32'h0000000C, 32'h0, q);
		`CHK("unmapped", 32'h0, q)
		$display("test reset done");
	endtask
	task automatic t_address();
		for (int i = 0; i < 9; i++) begin
			pin_lo <= dpsa_pin_t'(i % 3);
			pin_hi <= dpsa_pin_t'(i / 3);
			repeat (4) @(posedge hclk);
			dev_a = `DPSA_ADDR_BASE + 7'(3 * (i / 3) + i % 3);
			step(OP_START, 8'h00);
			put({dev_a, 1'b0}, 1'b1);
			step(OP_STOP, 8'h00);
		end
		step(OP_START, 8'h00);
		put({dev_a + 7'h09, 1'b0}, 1'b0);
		put(8'h00, 1'b0);
		put(8'h11, 1'b0);
		step(OP_STOP, 8'h00);
		`CHK("wiper", 8'h80, wiper)
		$display("test address done");
	endtask
	task automatic t_wiper();
		step(OP_START, 8'h00);
		put({dev_a, 1'b0}, 1'b1);
		put({`DPSA_CMD_WIPER, 5'h00}, 1'b1);
		put(8'h35, 1'b1);
		`CHK("wiper", 8'h35, wiper)
		put(8'hCA, 1'b1);
		`CHK("wiper", 8'hCA, wiper)
		step(OP_STOP, 8'h00);
		rd_ptr({`DPSA_CMD_WIPER, 5'h00});
		get(OP_READ_ACK, 8'hCA);
		get(OP_READ_NACK, 8'hCA);
		step(OP_STOP, 8'h00);
		$display("test wiper done");
	endtask
	task automatic t_tolerance();
		rd_ptr({`DPSA_CMD_NV, `DPSA_TOL_HI_LOC});
		get(OP_READ_ACK, TOL_I);
		get(OP_READ_NACK, TOL_F);
		step(OP_STOP, 8'h00);
		rd_ptr({`DPSA_CMD_NV, `DPSA_TOL_LO_LOC});
		get(OP_READ_NACK, TOL_F);
		step(OP_STOP, 8'h00);
		$display("test tolerance done");
	endtask
	task automatic t_nv();
		wr_xfer({`DPSA_CMD_NV, 5'h03}, 8'h5A, 1'b1);
		`CHK("nv busy", 1'b1, nv_busy)
		step(OP_START, 8'h00);
		put({dev_a, 1'b0}, 1'b0);
		step(OP_STOP, 8'h00);
		wait_nv();
		rd_ptr({`DPSA_CMD_NV, 5'h03});
		get(OP_READ_NACK, 8'h5A);
		step(OP_STOP, 8'h00);
		$display("test nonvolatile done");
	endtask
	task automatic t_protect();
		wr_xfer({`DPSA_CMD_WP, 5'h00}, 8'h01, 1'b1);
		`CHK("protect", 1'b1, wp_active)
		wr_xfer({`DPSA_CMD_STORE, `DPSA_STORE_LOC}, 8'h00, 1'b0);
		wait_nv();
		wr_xfer({`DPSA_CMD_WP, 5'h00}, 8'hFE, 1'b1);
		`CHK("protect", 1'b0, wp_active)
		wr_xfer({`DPSA_CMD_RESTORE, `DPSA_STORE_LOC}, 8'h00, 1'b0);
		wait_nv();
		`CHK("wiper", 8'h80, wiper)
		wr_xfer({`DPSA_CMD_WIPER, 5'h00}, 8'h44, 1'b1);
		wr_xfer({`DPSA_CMD_STORE, `DPSA_STORE_LOC}, 8'h00, 1'b0);
		wait_nv();
		wr_xfer({`DPSA_CMD_WIPER, 5'h00}, 8'h11, 1'b1);
		wr_xfer({`DPSA_CMD_RESTORE, `DPSA_STORE_LOC}, 8'h00, 1'b0);
		wait_nv();
		`CHK("wiper", 8'h44, wiper)
		$display("test protect done");
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// clock, reset, run
	// ----------------------------------------
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cyc++;
		if (cyc == LIMIT) begin
			err_count++;
			wrap_up();
		end
	end
	initial begin
		hresetn = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		pin_lo = PIN_GND;
		pin_hi = PIN_GND;
		err_count = 0;
		check_count = 0;
		cyc = 0;
		dev_a = `DPSA_ADDR_BASE;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		t_reset();
		t_address();
		t_wiper();
		t_tolerance();
		t_nv();
		t_protect();
		wrap_up();
	end
endmodule

// *** hdl/dpsa_dev.sv ***
// Notes on behaviour
// - master points with dummy address and instruction
// - read source chosen by pointing instruction
// - tolerance bytes readable together or singly
// - master repeats start, resends address with read
// - after read-address ack device drives selected byte
// - stop ends every transfer
// - write: master raises sda in ninth clock
// - read: master leaves sda high in ninth clock after last byte only
// - master pulls low, then raises for stop
// - wiper updates on every further data byte
// - new operation needs a new transfer
// - wiper readable repeatedly in one transfer
// - data sampled on serial clock rising edge
// - tri-state strap pins decode slave address
// - instruction: three command bits, five location bits
// - write protect follows data byte bit zero
// - no address ack during nonvolatile write
// - tolerance pointer auto-advances to second byte
`timescale 1ns/1ps
`include "dpsa_regs.svh"
module dpsa_dev #(
	parameter int         NV_WRITE_US  = `DPSA_NV_WRITE_US,
	parameter logic [7:0] TOL_SIGN_INT = 8'h00,
	parameter logic [7:0] TOL_FRAC     = 8'h00
) (
	input  wire logic                hclk,              // clock
	input  wire logic                hresetn,           // async reset
	dpsa_if.dev_mp                   bus,               // two-wire link
	input  wire dpsa_pkg::dpsa_pin_t addr_sel_pin_low,  // strap pin, weight 1
	input  wire dpsa_pkg::dpsa_pin_t addr_sel_pin_high, // strap pin, weight 3
	output logic [7:0]               wiper,             // wiper setting
	output logic                     wp_active,         // write protect
	output logic                     nv_busy            // nv write cycle
);
	import dpsa_pkg::*;

	localparam int NV_CYC =
		(NV_WRITE_US * 1000 + `DPSA_CLK_NS - 1) / `DPSA_CLK_NS;
	localparam int BW = $clog2(NV_CYC + 1);

	// ----------------------------------------
	// pin sampling and bus events
	// ----------------------------------------
	logic [5:0]   sy;
	logic         scl_q;
	logic         sda_q;
	logic [6:0]   my_addr_q;
	dpsa_dev_st_t st_q;
	logic [3:0]   cnt_q;
	logic [7:0]   sr_q;
	logic [7:0]   tx_q;
	logic [2:0]   cmd_q;
	logic [4:0]   ptr_q;
	logic [7:0]   wiper_q;
	logic         wp_q;
	logic [7:0]   nv_q [0:31];
	logic [BW-1:0] busy_cnt_q;
	logic         busy_q;
	logic         sda_o_q;
	logic [7:0]   rd_byte;

	dpsa_sync #(.W(6)) u_sync (
		.clk  (hclk),
		.rstn (hresetn),
		.d    ({bus.scl, bus.sda, addr_sel_pin_high, addr_sel_pin_low}),
		.q    (sy)
	);

	function automatic logic [6:0] pin_num(input logic [1:0] p);
		case (p)
			PIN_GND: pin_num = 7'h00;
			PIN_VDD: pin_num = 7'h01;
			default: pin_num = 7'h02;
		endcase
	endfunction

	function automatic logic [6:0] slave_addr(input logic [1:0] hi,
		input logic [1:0] lo);
		slave_addr = 7'(`DPSA_ADDR_BASE + 7'h03 * pin_num(hi)
			+ pin_num(lo));
	endfunction

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scl_q     <= 1'b1;
			sda_q     <= 1'b1;
			my_addr_q <= `DPSA_ADDR_BASE;
		end else begin
			scl_q     <= sy[5];
			sda_q     <= sy[4];
			my_addr_q <= slave_addr(sy[3:2], sy[1:0]);
		end
	end

	wire scl_rise = sy[5] && !scl_q;
	wire scl_fall = !sy[5] && scl_q;
	wire start    = scl_q && sy[5] && sda_q && !sy[4];
	wire stop     = scl_q && sy[5] && !sda_q && sy[4];
	wire ack_slot = scl_fall && (cnt_q == `DPSA_ACK_BIT);
	// busy hides the device from polling until the cycle ends
	wire addr_hit = (sr_q[7:1] == my_addr_q) && !busy_q;
	wire go_ack   = ack_slot && ((st_q == DS_ADDR && addr_hit) ||
		st_q == DS_INSTR || st_q == DS_DATA);
	wire take_ins = ack_slot && (st_q == DS_INSTR);
	wire take_dat = ack_slot && (st_q == DS_DATA);
	wire rd_start = ack_slot && (st_q == DS_ADDR) && addr_hit && sr_q[0];
	wire m_ack    = scl_rise && (cnt_q == `DPSA_ACK_BIT) &&
		(st_q == DS_READ);
	wire nv_ok    = !wp_q && (ptr_q < `DPSA_TOL_HI_LOC);
	wire nv_wr    = take_dat && (cmd_q == `DPSA_CMD_NV) && nv_ok;
	wire st_wr    = take_ins && (sr_q[7:5] == `DPSA_CMD_STORE) && !wp_q;

	// ----------------------------------------
	// transfer sequencing
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= DS_IDLE;
		end else if (stop) begin
			st_q <= DS_IDLE;
		end else if (start) begin
			st_q <= DS_ADDR;
		end else if (ack_slot) begin
			case (st_q)
				DS_ADDR:  st_q <= !addr_hit ? DS_IGNORE :
					(sr_q[0] ? DS_READ : DS_INSTR);
				DS_INSTR: st_q <= DS_DATA;
				default:  st_q <= st_q;
			endcase
		end else if (m_ack && sy[4]) begin
			st_q <= DS_IGNORE; // master declined more bytes
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 4'h0;
		end else if (start) begin
			cnt_q <= 4'h0;
		end else if (scl_rise) begin
			cnt_q <= (cnt_q == `DPSA_ACK_BIT) ? 4'h0 : cnt_q + 4'h1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sr_q <= 8'h00;
		end else if (scl_rise && cnt_q < `DPSA_ACK_BIT) begin
			sr_q <= {sr_q[6:0], sy[4]};
		end
	end

	// ----------------------------------------
	// pointer and read data
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmd_q <= `DPSA_CMD_WIPER;
			ptr_q <= 5'h00;
		end else if (take_ins) begin
			cmd_q <= sr_q[7:5];
			ptr_q <= sr_q[4:0];
		end else if (ack_slot && st_q == DS_READ &&
			cmd_q == `DPSA_CMD_NV && ptr_q == `DPSA_TOL_HI_LOC) begin
			ptr_q <= `DPSA_TOL_LO_LOC;
		end
	end

	// the pointer survives the transfer, so a read may skip pointing
	always_comb begin
		if (cmd_q != `DPSA_CMD_NV) begin
			rd_byte = wiper_q;
		end else if (ptr_q == `DPSA_TOL_HI_LOC) begin
			rd_byte = TOL_SIGN_INT;
		end else if (ptr_q == `DPSA_TOL_LO_LOC) begin
			rd_byte = TOL_FRAC;
		end else begin
			rd_byte = nv_q[ptr_q];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_q <= 8'hFF;
		end else if (rd_start || (m_ack && !sy[4])) begin
			tx_q <= rd_byte;
		end else if (scl_rise && st_q == DS_READ &&
			cnt_q < `DPSA_ACK_BIT) begin
			tx_q <= {tx_q[6:0], 1'b1};
		end
	end

	// ----------------------------------------
	// sda drive, changed only while scl is low
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sda_o_q <= 1'b1;
		end else if (start || stop) begin
			sda_o_q <= 1'b1;
		end else if (scl_fall) begin
			if (go_ack) begin
				sda_o_q <= 1'b0;
			end else if (st_q == DS_READ && cnt_q < `DPSA_ACK_BIT) begin
				sda_o_q <= tx_q[7];
			end else begin
				sda_o_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// wiper, protect and nonvolatile store
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wiper_q <= 8'h80;
			wp_q    <= 1'b0;
			for (int i = 0; i < 32; i++) begin
				nv_q[i] <= 8'h80;
			end
		end else if (take_dat) begin
			case (cmd_q)
				`DPSA_CMD_WIPER: wiper_q <= sr_q;
				`DPSA_CMD_WP:    wp_q    <= sr_q[0];
				`DPSA_CMD_NV: begin
					if (nv_ok) begin
						nv_q[ptr_q] <= sr_q;
					end
				end
				default: wiper_q <= wiper_q;
			endcase
		end else if (take_ins) begin
			if (st_wr) begin
				nv_q[`DPSA_STORE_LOC] <= wiper_q;
			end else if (sr_q[7:5] == `DPSA_CMD_RESTORE) begin
				wiper_q <= nv_q[`DPSA_STORE_LOC];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy_cnt_q <= '0;
			busy_q     <= 1'b0;
		end else if (nv_wr || st_wr) begin
			busy_cnt_q <= BW'(NV_CYC);
			busy_q     <= 1'b1;
		end else if (busy_cnt_q != '0) begin
			busy_cnt_q <= busy_cnt_q - 1'b1;
			busy_q     <= (busy_cnt_q != BW'(1));
		end
	end

	assign bus.s_sda_o    = sda_o_q;
	assign bus.s_sda_oe_n = sda_o_q;
	assign wiper          = wiper_q;
	assign wp_active      = wp_q;
	assign nv_busy        = busy_q;
endmodule

// *** hdl/dpsa_host.sv ***
`timescale 1ns/1ps
`include "dpsa_regs.svh"
module dpsa_host #(
	parameter logic [15:0] DIV_RST = `DPSA_DIV_RST
) (
	input  wire logic        hclk,      // clock
	input  wire logic        hresetn,   // async reset
	input  wire logic        hsel,      // slave select
	input  wire logic [31:0] haddr,     // byte address
	input  wire logic [1:0]  htrans,    // transfer type
	input  wire logic        hwrite,    // write when high
	input  wire logic [2:0]  hsize,     // word only
	input  wire logic [31:0] hwdata,    // write data
	input  wire logic        hready,    // bus ready
	output logic             hreadyout, // ready except in reset
	output logic [31:0]      hrdata,    // read data
	output logic             hresp,     // always okay
	dpsa_if.host_mp          bus        // two-wire link
);
	import dpsa_pkg::*;

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	logic          ap_wr_q;
	logic [7:0]    ap_addr_q;
	logic [31:0]   hrdata_q;
	logic          rdy_q;
	logic [15:0]   div_q;
	logic [15:0]   div_cnt_q;
	dpsa_op_t      op_q;
	logic          pend_q;
	logic [7:0]    txs_q;
	logic [7:0]    rx_q;
	logic          ack_q;
	dpsa_host_st_t st_q;
	logic [1:0]    ph_q;
	logic [3:0]    bit_q;
	logic          scl_q;
	logic          sda_q;
	logic          sda_in;

	wire busy  = pend_q || (st_q != HS_IDLE);
	wire ap_ok = hsel && hready && htrans[1];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr_q   <= 1'b0;
			ap_addr_q <= 8'h00;
			hrdata_q  <= 32'h0;
			rdy_q     <= 1'b0;
		end else begin
			rdy_q   <= 1'b1;
			ap_wr_q <= ap_ok && hwrite;
			if (ap_ok) begin
				ap_addr_q <= haddr[7:0];
			end
			if (ap_ok && !hwrite) begin
				case (haddr[7:0])
					`DPSA_REG_STATUS: hrdata_q <= {16'h0, rx_q,
						6'h00, ack_q, busy};
					`DPSA_REG_DIV:    hrdata_q <= {16'h0, div_q};
					`DPSA_REG_CMD:    hrdata_q <= {16'h0, txs_q,
						5'h00, op_q};
					default:          hrdata_q <= 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_q <= DIV_RST;
		end else if (ap_wr_q && ap_addr_q == `DPSA_REG_DIV) begin
			div_q <= hwdata[15:0];
		end
	end

	// software builds each transfer from start, byte and stop steps;
	// a step written while busy is dropped
	wire cmd_wr = ap_wr_q && ap_addr_q == `DPSA_REG_CMD && !busy;
	wire tick   = (div_cnt_q == 16'h0);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt_q <= DIV_RST;
		end else begin
			div_cnt_q <= tick ? div_q : div_cnt_q - 16'h1;
		end
	end

	// ----------------------------------------
	// step sequencer, four ticks per bit
	// ----------------------------------------
	dpsa_sync #(.W(1)) u_sync (
		.clk  (hclk),
		.rstn (hresetn),
		.d    (bus.sda),
		.q    (sda_in)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			op_q   <= OP_NONE;
			pend_q <= 1'b0;
		end else if (cmd_wr) begin
			op_q   <= dpsa_op_t'(hwdata[`DPSA_OP_MSB:`DPSA_OP_LSB]);
			pend_q <= (hwdata[`DPSA_OP_MSB:`DPSA_OP_LSB] != OP_NONE);
		end else if (tick && st_q == HS_IDLE) begin
			pend_q <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q  <= HS_IDLE;
			ph_q  <= 2'h0;
			bit_q <= 4'h0;
		end else if (tick) begin
			ph_q <= ph_q + 2'h1;
			case (st_q)
				HS_IDLE: begin
					ph_q  <= 2'h0;
					bit_q <= 4'h0;
					if (pend_q) begin
						st_q <= (op_q == OP_START) ? HS_START :
							(op_q == OP_STOP) ? HS_STOP : HS_BYTE;
					end
				end
				HS_BYTE: begin
					if (ph_q == 2'h3) begin
						bit_q <= bit_q + 4'h1;
						if (bit_q == `DPSA_ACK_BIT) begin
							st_q <= HS_IDLE;
						end
					end
				end
				default: begin
					if (ph_q == 2'h3) begin
						st_q <= HS_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			txs_q <= 8'h00;
		end else if (cmd_wr) begin
			txs_q <= hwdata[`DPSA_DAT_MSB:`DPSA_DAT_LSB];
		end else if (tick && st_q == HS_BYTE && ph_q == 2'h3) begin
			txs_q <= {txs_q[6:0], 1'b1};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_q  <= 8'h00;
			ack_q <= 1'b0;
		end else if (tick && st_q == HS_BYTE && ph_q == 2'h2) begin
			if (bit_q < `DPSA_ACK_BIT) begin
				rx_q <= {rx_q[6:0], sda_in};
			end else if (op_q == OP_WRITE) begin
				ack_q <= !sda_in; // polled by software
			end
		end
	end

	// ----------------------------------------
	// line drive: scl changes only on phase 0, 1 and 3
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else if (tick) begin
			case (st_q)
				HS_START: begin // also a repeated start
					scl_q <= (ph_q == 2'h1 || ph_q == 2'h2);
					sda_q <= (ph_q == 2'h0 || ph_q == 2'h1);
				end
				HS_STOP: begin // low first, then rise with scl high
					scl_q <= (ph_q != 2'h0);
					sda_q <= (ph_q == 2'h2 || ph_q == 2'h3);
				end
				HS_BYTE: begin
					scl_q <= (ph_q == 2'h1 || ph_q == 2'h2);
					if (ph_q == 2'h0) begin
						if (bit_q < `DPSA_ACK_BIT) begin
							sda_q <= (op_q == OP_WRITE) ? txs_q[7] : 1'b1;
						end else begin
							sda_q <= (op_q != OP_READ_ACK);
						end
					end
				end
				default: begin
					scl_q <= scl_q;
					sda_q <= sda_q;
				end
			endcase
		end
	end

	assign bus.m_scl_o    = scl_q;
	assign bus.m_scl_oe_n = scl_q;
	assign bus.m_sda_o    = sda_q;
	assign bus.m_sda_oe_n = sda_q;
	assign hreadyout      = rdy_q;
	assign hrdata         = hrdata_q;
	assign hresp          = 1'b0;
endmodule

// *** hdl/dpsa_if.sv ***
`timescale 1ns/1ps
interface dpsa_if;
	logic scl;
	logic sda;
	logic m_scl_o;
	logic m_scl_oe_n;
	logic m_sda_o;
	logic m_sda_oe_n;
	logic s_sda_o;
	logic s_sda_oe_n;
	// open-drain wires: low wins, released means pulled high
	assign scl = !(!m_scl_oe_n && !m_scl_o);
	assign sda = !((!m_sda_oe_n && !m_sda_o) || (!s_sda_oe_n && !s_sda_o));
	modport dev_mp (input scl, sda, output s_sda_o, s_sda_oe_n);
	modport host_mp (input scl, sda,
		output m_scl_o, m_scl_oe_n, m_sda_o, m_sda_oe_n);
endinterface

// *** hdl/dpsa_pkg.sv ***
package dpsa_pkg;
	typedef enum logic [1:0] {
		PIN_GND  = 2'h0,
		PIN_VDD  = 2'h1,
		PIN_OPEN = 2'h2
	} dpsa_pin_t;
	typedef enum logic [2:0] {
		DS_IDLE   = 3'h0,
		DS_ADDR   = 3'h1,
		DS_INSTR  = 3'h3,
		DS_DATA   = 3'h2,
		DS_READ   = 3'h6,
		DS_IGNORE = 3'h7
	} dpsa_dev_st_t;
	typedef enum logic [1:0] {
		HS_IDLE  = 2'h0,
		HS_START = 2'h1,
		HS_BYTE  = 2'h3,
		HS_STOP  = 2'h2
	} dpsa_host_st_t;
	typedef enum logic [2:0] {
		OP_NONE      = 3'h0,
		OP_START     = 3'h1,
		OP_WRITE     = 3'h2,
		OP_READ_ACK  = 3'h3,
		OP_READ_NACK = 3'h4,
		OP_STOP      = 3'h5
	} dpsa_op_t;
endpackage

// *** hdl/dpsa_regs.svh ***
`ifndef DPSA_REGS_SVH
`define DPSA_REGS_SVH
// ----------------------------------------
// serial command encoding
// ----------------------------------------
`define DPSA_CMD_WIPER   3'h0
`define DPSA_CMD_NV     3'h1
`define DPSA_CMD_WP     3'h2
`define DPSA_CMD_RESTORE 3'h5
`define DPSA_CMD_STORE  3'h6
`define DPSA_TOL_HI_LOC 5'h1E
`define DPSA_TOL_LO_LOC 5'h1F
`define DPSA_STORE_LOC  5'h00
`define DPSA_ADDR_BASE  7'h18
`define DPSA_ACK_BIT    4'h8
// ----------------------------------------
// host register map and fields
// ----------------------------------------
`define DPSA_REG_CMD    8'h00
`define DPSA_REG_STATUS 8'h04
`define DPSA_REG_DIV    8'h08
`define DPSA_OP_LSB     0
`define DPSA_OP_MSB     2
`define DPSA_DAT_LSB    8
`define DPSA_DAT_MSB    15
`define DPSA_ST_BUSY    0
`define DPSA_ST_ACK     1
`define DPSA_DIV_RST    16'h00FA
// ----------------------------------------
// timing
// ----------------------------------------
`define DPSA_CLK_NS     5
`define DPSA_NV_WRITE_US 20
`endif

// *** hdl/dpsa_sync.sv ***
`timescale 1ns/1ps
module dpsa_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,  // clock
	input  wire logic         rstn, // async reset, active low
	input  wire logic [W-1:0] d,    // asynchronous inputs
	output logic      [W-1:0] q     // synchronised outputs
);
	logic [W-1:0] meta_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= '1;
			q      <= '1;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule
